// ---- dnv_asserts.sv ----
// assertion checker for the network variable interpreter
`timescale 1ns/1ps
module dnv_asserts (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // network requests
  input wire obj_req_stb,
  input wire [15:0] obj_req_id,
  input wire [7:0] obj_req_code,
  input wire spd_stpt_stb,
  input wire [7:0] spd_stpt_state,
  input wire cw_stb,
  input wire [15:0] cw_val,
  // drive side
  input wire drv_comm_ok,
  input wire drv_run,
  input wire drv_freq_mode,
  input wire [15:0] drv_speed_rpm,
  input wire drv_fault_reset,
  input wire drv_cw_active,
  // network outputs
  input wire [31:0] object_status_output,
  input wire object_status_send,
  input wire [15:0] speed_feedback_output,
  input wire [15:0] frequency_feedback_output,
  input wire feedback_send
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire id_ok = obj_req_id <= 16'h0001;
  sequence s_block;
    obj_req_stb && id_ok && obj_req_code == 8'h01 && !drv_cw_active && !cw_stb;
  endsequence
  sequence s_stop;
    spd_stpt_stb && spd_stpt_state != 8'h01 && !drv_cw_active && !cw_stb;
  endsequence
  // two cycles down so the snapshot behind the send already saw the lost link
  sequence s_no_link;
    (!drv_comm_ok) [*2] ##0 feedback_send;
  endsequence
  AST_STATUS_SEND: assert property (obj_req_stb |=> object_status_send)
    else $error("status not sent after request");
  AST_STATUS_QUIET: assert property (!obj_req_stb |=> !object_status_send)
    else $error("status sent without request");
  AST_BAD_ID: assert property (obj_req_stb && !id_ok |=> object_status_output[0] && !drv_fault_reset)
    else $error("bad id not flagged or acted on");
  AST_BLOCK: assert property (s_block |=> object_status_output[2] ##1 !drv_run)
    else $error("block request did not stop drive");
  AST_STOP_STATE: assert property (s_stop |=> ##1 !drv_run)
    else $error("drive runs with setpoint state not on");
  AST_FAULT_RESET: assert property (drv_fault_reset |-> $past(obj_req_stb && id_ok && obj_req_code == 8'h0a && !drv_cw_active))
    else $error("fault reset without allowed request");
  AST_CW_ON: assert property (cw_stb && cw_val != 16'h0000 |-> ##[1:2] drv_cw_active)
    else $error("nonzero control word not taken");
  AST_CW_OFF: assert property (cw_stb && cw_val == 16'h0000 |-> ##[1:2] !drv_cw_active)
    else $error("zero control word left override on");
  AST_FREQ_NO_SPEED: assert property (drv_freq_mode |-> drv_speed_rpm == 16'h0000)
    else $error("speed request while frequency in control");
  AST_NO_LINK: assert property (s_no_link |-> speed_feedback_output == 16'h7fff && frequency_feedback_output == 16'h8000)
    else $error("feedback not invalid with link down");
endmodule // dnv_asserts

bind dnv_interp dnv_asserts dnv_asserts_inst (.*);

// ---- dnv_drive_model.sv ----
// behavioural drive core answering the interpreter's commands
`timescale 1ns/1ps
module dnv_drive_model (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // commands
  input wire drv_run,
  input wire drv_fault_reset,
  input wire drv_timeout_fault,
  // bench controls
  input wire trip,
  input wire link_ok,
  // feedback
  output reg [15:0] drv_status_word,
  output reg [15:0] drv_speed_level,
  output reg [15:0] drv_freq_tenths,
  output reg drv_fault,
  output reg drv_comm_ok
);
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_fault <= 1'b0;
      drv_comm_ok <= 1'b1;
      drv_freq_tenths <= 16'h0000;
    end else begin
      drv_comm_ok <= link_ok;
      if (trip || drv_timeout_fault) drv_fault <= 1'b1;
      else if (drv_fault_reset) drv_fault <= 1'b0;
      // with no contact the frequency reading is garbage, never a held value
      if (!link_ok) drv_freq_tenths <= drv_freq_tenths + 16'h0001;
    end
  end
  always @* begin
    drv_status_word = {12'h000, drv_fault, 1'b0, drv_run, 1'b1};
    drv_speed_level = drv_run ? 16'h4e20 : 16'h0000;
  end
endmodule // dnv_drive_model

// ---- dnv_interp.v ----
// drive network variable interpreter: requests, setpoints, limits, feedback
`timescale 1ns/1ps
`include "dnv_regs.vh"

module dnv_interp #(
  parameter TICK_CYCLES = `DNV_TICK_NS / `DNV_CLK_NS
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wr_data,
  input wire reg_wr_en,
  input wire reg_rd_en,
  output reg [31:0] reg_rd_data,
  // network inputs
  input wire node_online,
  input wire obj_req_stb,
  input wire [15:0] obj_req_id,
  input wire [7:0] obj_req_code,
  input wire spd_stpt_stb,
  input wire [7:0] spd_stpt_pct,
  input wire [7:0] spd_stpt_state,
  input wire scale_stb,
  input wire [15:0] scale_val,
  input wire freq_stpt_stb,
  input wire [15:0] freq_stpt_val,
  input wire cw_stb,
  input wire [15:0] cw_val,
  // drive core feedback
  input wire [15:0] drv_status_word,
  input wire [15:0] drv_speed_level,
  input wire [15:0] drv_freq_tenths,
  input wire drv_fault,
  input wire drv_comm_ok,
  // drive core commands
  output reg drv_run,
  output reg drv_freq_mode,
  output reg [15:0] drv_speed_rpm,
  output reg [15:0] drv_freq_hz,
  output reg drv_fault_reset,
  output reg drv_timeout_fault,
  output reg drv_cw_active,
  output reg [15:0] drv_cw,
  // network outputs
  output reg [31:0] object_status_output,
  output reg object_status_send,
  output reg [15:0] drive_status_output,
  output reg [15:0] speed_feedback_output,
  output reg [15:0] frequency_feedback_output,
  output reg feedback_send
);

  localparam integer TICK_LAST_FULL = TICK_CYCLES - 1;
  // 22 bits hold the default tick span; a longer tick needs a wider counter
  localparam [21:0] TICK_LAST = TICK_LAST_FULL[21:0];

  // configuration
  reg [15:0] nominal_speed_config;
  reg [15:0] maximum_speed_config;
  reg [15:0] minimum_speed_config;
  reg [15:0] min_send_interval_config;
  reg [15:0] send_heartbeat_config;
  reg [15:0] receive_timeout_config;
  reg [15:0] scale_default_config;
  reg [15:0] freq_lo_reg;
  reg [15:0] freq_hi_reg;

  // stored network inputs
  reg [7:0] stpt_state_reg;
  reg [7:0] stpt_pct_reg;
  reg [15:0] scale_reg;
  reg [15:0] freq_stpt_reg;
  reg blocked_reg;
  reg fresh_reg;
  reg online_q_reg;

  // timers
  reg [21:0] tick_cnt_reg;
  reg tick_reg;
  reg [15:0] rcv_cnt_reg;
  reg [15:0] since_send_reg;

  // request decode
  reg blocked_next;
  reg fault_reset_next;
  reg [31:0] status_next;
  reg [15:0] flags;
  reg [15:0] mask;
  reg wipe;

  wire override = (drv_cw != `DNV_CW_RST);
  wire id_ok = (obj_req_id <= `DNV_ID_MAX);
  wire in_alarm = drv_fault | drv_timeout_fault;
  wire freq_mode = (freq_stpt_reg != `DNV_FREQ_NONE_LO) &&
                   (freq_stpt_reg != `DNV_FREQ_NONE_HI);

  function [0:0] in_range;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
  endfunction

  always @* begin
    blocked_next = blocked_reg;
    fault_reset_next = 1'b0;
    status_next = object_status_output;
    flags = 16'h0000;
    mask = 16'h0000;
    wipe = 1'b0;
    if (obj_req_stb) begin
      if (!id_ok) begin
        flags[`DNV_ST_INVALID_ID] = 1'b1;
      end else begin
        case (obj_req_code)
          `DNV_REQ_RESUME_CONTROL, `DNV_REQ_ALLOW_CONTROL: begin
            if (!override)
              blocked_next = 1'b0;
          end
          `DNV_REQ_BLOCK_CONTROL: begin
            if (!override)
              blocked_next = 1'b1;
          end
          `DNV_REQ_REFRESH_STATUS: begin
            wipe = 1'b0;
          end
          `DNV_REQ_WIPE_STATUS: begin
            wipe = 1'b1;
          end
          `DNV_REQ_LIST_SUPPORTED: begin
            mask = `DNV_SUPPORTED_MASK;
            flags[`DNV_ST_REPORT_MASK] = 1'b1;
          end
          `DNV_REQ_FAULT_RESET: begin
            if (!override)
              fault_reset_next = 1'b1;
          end
          default: begin
            flags[`DNV_ST_INVALID_REQ] = 1'b1;
          end
        endcase
      end
      flags[`DNV_ST_DISABLED] = blocked_next;
      flags[`DNV_ST_COMM_FAIL] = !drv_comm_ok;
      flags[`DNV_ST_IN_ALARM] = in_alarm;
      status_next = wipe ? 32'h00000000 : {mask, flags};
    end
  end

  // speed path: pct in 0.5 % steps times scale in 0.005 % steps
  wire signed [24:0] pct_scale = $signed({1'b0, stpt_pct_reg}) * $signed(scale_reg);
  wire signed [24:0] level_raw = pct_scale / `DNV_PCT_FULL;
  reg signed [15:0] level_clamped;
  always @* begin
    level_clamped = level_raw[15:0];
    if (level_raw > $signed({{9{maximum_speed_config[15]}}, maximum_speed_config}))
      level_clamped = maximum_speed_config;
    else if (level_raw < $signed({{9{minimum_speed_config[15]}}, minimum_speed_config}))
      level_clamped = minimum_speed_config;
  end
  wire signed [32:0] rpm_prod = level_clamped * $signed({1'b0, nominal_speed_config});
  wire signed [32:0] rpm_full = rpm_prod / `DNV_LVL_FULL;
  wire [15:0] rpm_next = (freq_mode || nominal_speed_config == `DNV_NOM_INVALID) ?
                         16'h0000 : rpm_full[15:0];
  wire signed [15:0] hz_next = $signed(freq_stpt_reg) / `DNV_FREQ_DIV;

  // stopping: override follows the control word, otherwise state and enable
  wire run_next = override ? drv_cw[`DNV_CW_ON_BIT] :
                  ((stpt_state_reg == `DNV_STATE_ON) && !blocked_reg && fresh_reg &&
                   node_online);

  // feedback snapshot and send pacing
  wire [15:0] speed_fb = drv_comm_ok ? drv_speed_level : `DNV_SPEED_INVALID;
  wire [15:0] freq_fb = drv_comm_ok ? drv_freq_tenths : `DNV_FREQ_INVALID;
  wire changed = {drv_status_word, speed_fb, freq_fb} !=
                 {drive_status_output, speed_feedback_output, frequency_feedback_output};
  wire may_send = (min_send_interval_config == 16'h0000) ||
                  (since_send_reg >= min_send_interval_config);
  // heartbeat wins over the minimum interval
  wire hb_due = (send_heartbeat_config != 16'h0000) &&
                (since_send_reg >= send_heartbeat_config);
  wire send_now = (changed && may_send) || hb_due;

  wire timeout_hit = (receive_timeout_config != 16'h0000) &&
                     (rcv_cnt_reg >= receive_timeout_config);

  // 0.1 s tick shared by every timer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 22'h000000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == TICK_LAST);
      if (tick_cnt_reg == TICK_LAST)
        tick_cnt_reg <= 22'h000000;
      else
        tick_cnt_reg <= tick_cnt_reg + 22'h000001;
    end
  end

  // network inputs, request state and drive commands
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stpt_state_reg <= `DNV_STATE_RST;
      stpt_pct_reg <= 8'h00;
      scale_reg <= `DNV_SCALE_DEF_RST;
      freq_stpt_reg <= `DNV_FREQ_STPT_RST;
      blocked_reg <= 1'b0;
      fresh_reg <= 1'b0;
      online_q_reg <= 1'b0;
      rcv_cnt_reg <= 16'h0000;
      object_status_output <= 32'h00000000;
      object_status_send <= 1'b0;
      drv_run <= 1'b0;
      drv_freq_mode <= 1'b0;
      drv_speed_rpm <= 16'h0000;
      drv_freq_hz <= 16'h0000;
      drv_fault_reset <= 1'b0;
      drv_timeout_fault <= 1'b0;
      drv_cw_active <= 1'b0;
      drv_cw <= `DNV_CW_RST;
    end else begin
      online_q_reg <= node_online;
      blocked_reg <= blocked_next;
      object_status_output <= status_next;
      object_status_send <= obj_req_stb;
      drv_fault_reset <= fault_reset_next;
      if (cw_stb)
        drv_cw <= cw_val;
      drv_cw_active <= override;
      // a setpoint that arrives while blocking is dropped, as is old state
      if (blocked_next && !blocked_reg)
        fresh_reg <= 1'b0;
      else if (spd_stpt_stb && !blocked_reg)
        fresh_reg <= 1'b1;
      if (spd_stpt_stb && !blocked_reg) begin
        stpt_state_reg <= spd_stpt_state;
        stpt_pct_reg <= spd_stpt_pct;
      end
      if (scale_stb && !blocked_reg)
        scale_reg <= scale_val;
      else if (node_online && !online_q_reg)
        scale_reg <= scale_default_config;
      if (freq_stpt_stb && ((freq_stpt_val == `DNV_FREQ_NONE_LO) ||
          (freq_stpt_val == `DNV_FREQ_NONE_HI) ||
          in_range(freq_stpt_val, freq_lo_reg, freq_hi_reg)))
        freq_stpt_reg <= freq_stpt_val;
      if (spd_stpt_stb)
        rcv_cnt_reg <= 16'h0000;
      else if (tick_reg && rcv_cnt_reg != 16'hffff)
        rcv_cnt_reg <= rcv_cnt_reg + 16'h0001;
      // a timeout seen in the clearing cycle keeps the fault set
      if (timeout_hit)
        drv_timeout_fault <= 1'b1;
      else if (fault_reset_next)
        drv_timeout_fault <= 1'b0;
      drv_run <= run_next;
      drv_freq_mode <= freq_mode;
      drv_speed_rpm <= rpm_next;
      drv_freq_hz <= hz_next;
    end
  end

  // feedback outputs
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_send_reg <= 16'h0000;
      drive_status_output <= 16'h0000;
      speed_feedback_output <= `DNV_SPEED_INVALID;
      frequency_feedback_output <= `DNV_FREQ_INVALID;
      feedback_send <= 1'b0;
    end else begin
      feedback_send <= send_now;
      if (send_now) begin
        since_send_reg <= 16'h0000;
        drive_status_output <= drv_status_word;
        speed_feedback_output <= speed_fb;
        frequency_feedback_output <= freq_fb;
      end else if (tick_reg && since_send_reg != 16'hffff) begin
        since_send_reg <= since_send_reg + 16'h0001;
      end
    end
  end

  // register port
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nominal_speed_config <= `DNV_NOM_SPEED_RST;
      maximum_speed_config <= `DNV_MAX_SPEED_RST;
      minimum_speed_config <= `DNV_MIN_SPEED_RST;
      min_send_interval_config <= `DNV_TIME_RST;
      send_heartbeat_config <= `DNV_TIME_RST;
      receive_timeout_config <= `DNV_TIME_RST;
      scale_default_config <= `DNV_SCALE_DEF_RST;
      freq_lo_reg <= `DNV_FREQ_LO_RST;
      freq_hi_reg <= `DNV_FREQ_HI_RST;
      reg_rd_data <= 32'h00000000;
    end else begin
      if (reg_wr_en) begin
        case (reg_addr)
          `DNV_OFS_NOM_SPEED: nominal_speed_config <= reg_wr_data[15:0];
          // a limit that would cross the other one is refused
          `DNV_OFS_MAX_SPEED: begin
            if ($signed(reg_wr_data[15:0]) >= $signed(minimum_speed_config))
              maximum_speed_config <= reg_wr_data[15:0];
          end
          `DNV_OFS_MIN_SPEED: begin
            if ($signed(reg_wr_data[15:0]) <= $signed(maximum_speed_config))
              minimum_speed_config <= reg_wr_data[15:0];
          end
          `DNV_OFS_MIN_SEND: min_send_interval_config <= reg_wr_data[15:0];
          `DNV_OFS_SEND_HB: send_heartbeat_config <= reg_wr_data[15:0];
          `DNV_OFS_RCV_TIMEOUT: receive_timeout_config <= reg_wr_data[15:0];
          `DNV_OFS_SCALE_DEF: scale_default_config <= reg_wr_data[15:0];
          `DNV_OFS_FREQ_LIMIT: begin
            freq_lo_reg <= reg_wr_data[15:0];
            freq_hi_reg <= reg_wr_data[31:16];
          end
          default: begin
          end
        endcase
      end
      if (reg_rd_en) begin
        case (reg_addr)
          `DNV_OFS_NOM_SPEED: reg_rd_data <= {16'h0000, nominal_speed_config};
          `DNV_OFS_MAX_SPEED: reg_rd_data <= {16'h0000, maximum_speed_config};
          `DNV_OFS_MIN_SPEED: reg_rd_data <= {16'h0000, minimum_speed_config};
          `DNV_OFS_MIN_SEND: reg_rd_data <= {16'h0000, min_send_interval_config};
          `DNV_OFS_SEND_HB: reg_rd_data <= {16'h0000, send_heartbeat_config};
          `DNV_OFS_RCV_TIMEOUT: reg_rd_data <= {16'h0000, receive_timeout_config};
          `DNV_OFS_SCALE_DEF: reg_rd_data <= {16'h0000, scale_default_config};
          `DNV_OFS_FREQ_LIMIT: reg_rd_data <= {freq_hi_reg, freq_lo_reg};
          `DNV_OFS_STATE: reg_rd_data <= {16'h0000, stpt_state_reg, 2'b00,
                                          drv_timeout_fault, drv_freq_mode,
                                          override, fresh_reg, blocked_reg, drv_run};
          `DNV_OFS_REQUESTED: reg_rd_data <= {drv_speed_rpm, drv_freq_hz};
          default: reg_rd_data <= 32'h00000000;
        endcase
      end else begin
        reg_rd_data <= 32'h00000000;
      end
    end
  end

endmodule // dnv_interp

// ---- dnv_interp_test.sv ----
// self-checking bench for the network variable interpreter
`timescale 1ns/1ps
module dnv_interp_test;
  reg ref_clk, rst_n, reg_wr_en, reg_rd_en, node_online, obj_req_stb, spd_stpt_stb;
  reg scale_stb, freq_stpt_stb, cw_stb, trip, link_ok;
  reg [7:0] reg_addr, obj_req_code, spd_stpt_pct, spd_stpt_state;
  reg [31:0] reg_wr_data, st, rv;
  reg [15:0] obj_req_id, scale_val, freq_stpt_val, cw_val, sc;
  wire [31:0] reg_rd_data, object_status_output;
  wire [15:0] drv_status_word, drv_speed_level, drv_freq_tenths, drv_speed_rpm, drv_freq_hz;
  wire [15:0] drv_cw, drive_status_output, speed_feedback_output, frequency_feedback_output;
  wire drv_fault, drv_comm_ok, drv_run, drv_freq_mode, drv_fault_reset, drv_timeout_fault;
  wire drv_cw_active, object_status_send, feedback_send;
  integer errors, n_checks, seed, i, e;
  // short tick so the receive timeout shows within the run
  dnv_interp #(.TICK_CYCLES(4)) dnv_interp_inst (.*);
  dnv_drive_model dnv_drive_model_inst (.*);
  task test_done;
    begin
      if (errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk_w(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_b(input got, input exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
      end
    end
  endtask
  task tk(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr_en <= 1'b1;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
      tk(1);
    end
  endtask
  task rd(input [7:0] a);
    begin
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge ref_clk);
      reg_rd_en <= 1'b0;
      #1 rv = reg_rd_data;
      tk(1);
    end
  endtask
  task obj(input [15:0] id, input [7:0] c);
    begin
      obj_req_id <= id;
      obj_req_code <= c;
      obj_req_stb <= 1'b1;
      @(posedge ref_clk);
      obj_req_stb <= 1'b0;
      #1 st = object_status_output;
      tk(2);
    end
  endtask
  // k: 0 speed setpoint, 1 scale, 2 frequency, 3 control word
  task nv(input integer k, input [15:0] v, input [7:0] s);
    begin
      spd_stpt_pct <= v[7:0];
      spd_stpt_state <= s;
      scale_val <= v;
      freq_stpt_val <= v;
      cw_val <= v;
      {spd_stpt_stb, scale_stb, freq_stpt_stb, cw_stb} <= 4'h8 >> k;
      @(posedge ref_clk);
      {spd_stpt_stb, scale_stb, freq_stpt_stb, cw_stb} <= 4'h0;
      tk(3);
    end
  endtask
  // nominal 1420 rpm, limits -163.84 % .. 50 % as configured below
  function [15:0] exp_rpm(input integer pct, input [15:0] s);
    integer l;
    begin
      l = pct * $signed(s) / 200;
      if (l > 10000) l = 10000;
      if (l < -32768) l = -32768;
      l = l * 1420 / 20000;
      exp_rpm = l[15:0];
    end
  endfunction
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors = errors + 1;
    test_done;
  end
  initial begin
    {reg_wr_en, reg_rd_en, node_online, obj_req_stb, spd_stpt_stb, scale_stb} = 6'h00;
    {freq_stpt_stb, cw_stb, trip, rst_n, link_ok} = 5'h01;
    {reg_addr, obj_req_code, spd_stpt_pct, spd_stpt_state, reg_wr_data} = 64'h0;
    {obj_req_id, scale_val, freq_stpt_val, cw_val} = 64'h0;
    errors = 0;
    n_checks = 0;
    seed = 32'hc05c;
    tk(3);
    chk_b(drv_run, 1'b0);
    chk_w(speed_feedback_output, 16'h7fff);
    chk_w(frequency_feedback_output, 16'h8000);
    rst_n <= 1'b1;
    tk(1);
    wr(8'h20, 32'h0);
    rd(8'h20);
    chk_w(rv[15:8], 8'hff);
    chk_b(rv[4], 1'b0);
    wr(8'h18, 32'h00004e20);
    node_online <= 1'b1;
    wr(8'h00, 32'h0000058c);
    wr(8'h08, 32'h00008000);
    wr(8'h04, 32'h00002710);
    wr(8'h08, 32'h00003000);
    rd(8'h08);
    chk_w(rv, 32'h00008000);
    rd(8'h40);
    chk_w(rv, 32'h0);
    obj(16'h0002, 8'h01);
    chk_b(st[0], 1'b1);
    nv(0, 16'h00c8, 8'h01);
    chk_b(drv_run, 1'b1);
    chk_w(drv_speed_rpm, exp_rpm(200, 16'h4e20));
    sc = 16'h8000;
    for (i = 0; i < 8; i = i + 1) begin
      e = $random(seed);
      nv(1, sc, 8'h00);
      nv(0, {8'h00, e[23:16] % 8'hc9}, 8'h01);
      chk_w(drv_speed_rpm, exp_rpm(e[23:16] % 8'hc9, sc));
      sc = e[15:0];
    end
    nv(1, sc, 8'h00);
    chk_w(drive_status_output, 16'h0003);
    for (i = 0; i < 2; i = i + 1) begin
      obj(16'h0000, 8'h01);
      chk_b(st[2], 1'b1);
      chk_b(drv_run, 1'b0);
      nv(1, 16'h0100, 8'h00);
      nv(0, 16'h00c8, 8'h01);
      chk_b(drv_run, 1'b0);
      obj(16'h0001, i ? 8'h07 : 8'h00);
      chk_b(drv_run, 1'b0);
      nv(0, 16'h00c8, 8'h01);
      chk_b(drv_run, 1'b1);
      chk_w(drv_speed_rpm, exp_rpm(200, sc));
    end
    for (i = 0; i < 16; i = i + 1) begin
      obj(16'h0000, i[7:0]);
      if (i == 2) chk_b(st[1], 1'b0);
      if (i == 5) chk_w(st[31:16], 16'h06a7);
      if (i == 5) chk_b(st[2], 1'b1);
      if (i == 9) chk_w(st, 32'h0);
      if (i == 3 || i == 4 || i == 6 || i == 8 || i > 10) chk_b(st[1], 1'b1);
    end
    nv(0, 16'h00c8, 8'h01);
    nv(0, 16'h00c8, 8'h00);
    chk_b(drv_run, 1'b0);
    nv(0, 16'h00c8, 8'hff);
    chk_b(drv_run, 1'b0);
    trip <= 1'b1;
    tk(2);
    trip <= 1'b0;
    obj(16'h0000, 8'h02);
    chk_b(st[4], 1'b1);
    nv(3, 16'h0001, 8'h00);
    chk_b(drv_cw_active, 1'b1);
    chk_w(drv_cw, 16'h0001);
    chk_b(drv_run, 1'b1);
    obj(16'h0000, 8'h0a);
    chk_b(drv_fault, 1'b1);
    obj(16'h0000, 8'h01);
    chk_b(drv_run, 1'b1);
    nv(3, 16'h0000, 8'h00);
    chk_b(drv_cw_active, 1'b0);
    obj(16'h0000, 8'h0a);
    chk_b(drv_fault, 1'b0);
    for (i = 0; i < 2; i = i + 1) begin
      nv(2, 16'hfecf, 8'h00);
      chk_b(drv_freq_mode, 1'b1);
      chk_w(drv_freq_hz, 16'hffe2);
      nv(2, i ? 16'h8000 : 16'h7fff, 8'h00);
      chk_b(drv_freq_mode, 1'b0);
    end
    wr(8'h1c, 32'h03e8fc18);
    nv(2, 16'h03e9, 8'h00);
    chk_b(drv_freq_mode, 1'b0);
    nv(2, 16'hfc18, 8'h00);
    chk_w(drv_freq_hz, 16'hff9c);
    link_ok <= 1'b0;
    tk(6);
    chk_w(speed_feedback_output, 16'h7fff);
    chk_w(frequency_feedback_output, 16'h8000);
    obj(16'h0000, 8'h02);
    chk_b(st[3], 1'b1);
    link_ok <= 1'b1;
    chk_b(drv_timeout_fault, 1'b0);
    wr(8'h14, 32'h00000002);
    tk(20);
    chk_b(drv_timeout_fault, 1'b1);
    // heartbeat of one tick outruns a long minimum interval: one send per 4 cycles
    wr(8'h0c, 32'h00000100);
    wr(8'h10, 32'h00000001);
    tk(8);
    e = 0;
    for (i = 0; i < 16; i = i + 1) begin
      tk(1);
      e = e + feedback_send;
    end
    chk_w(e, 32'h00000004);
    test_done;
  end
endmodule // dnv_interp_test

// ---- dnv_regs.vh ----
// constants for the drive network variable interpreter
`ifndef DNV_REGS_VH
`define DNV_REGS_VH

// register byte offsets
`define DNV_OFS_NOM_SPEED 8'h00
`define DNV_OFS_MAX_SPEED 8'h04
`define DNV_OFS_MIN_SPEED 8'h08
`define DNV_OFS_MIN_SEND 8'h0c
`define DNV_OFS_SEND_HB 8'h10
`define DNV_OFS_RCV_TIMEOUT 8'h14
`define DNV_OFS_SCALE_DEF 8'h18
`define DNV_OFS_FREQ_LIMIT 8'h1c
`define DNV_OFS_STATE 8'h20
`define DNV_OFS_REQUESTED 8'h24

// reset values
`define DNV_NOM_SPEED_RST 16'h7fff
`define DNV_MAX_SPEED_RST 16'h4e20
`define DNV_MIN_SPEED_RST 16'h0000
`define DNV_TIME_RST 16'h0000
`define DNV_SCALE_DEF_RST 16'h0000
`define DNV_FREQ_LO_RST 16'h8001
`define DNV_FREQ_HI_RST 16'h7ffe
`define DNV_FREQ_STPT_RST 16'h7fff
`define DNV_STATE_RST 8'hff
`define DNV_CW_RST 16'h0000

// special codes
`define DNV_FREQ_NONE_LO 16'h8000
`define DNV_FREQ_NONE_HI 16'h7fff
`define DNV_SPEED_INVALID 16'h7fff
`define DNV_FREQ_INVALID 16'h8000
`define DNV_NOM_INVALID 16'h7fff
`define DNV_STATE_ON 8'h01
`define DNV_ID_MAX 16'h0001
`define DNV_CW_ON_BIT 0

// object request codes
`define DNV_REQ_RESUME_CONTROL 8'h00
`define DNV_REQ_BLOCK_CONTROL 8'h01
`define DNV_REQ_REFRESH_STATUS 8'h02
`define DNV_REQ_LIST_SUPPORTED 8'h05
`define DNV_REQ_ALLOW_CONTROL 8'h07
`define DNV_REQ_WIPE_STATUS 8'h09
`define DNV_REQ_FAULT_RESET 8'h0a
`define DNV_SUPPORTED_MASK 16'h06a7

// object status flag positions
`define DNV_ST_INVALID_ID 0
`define DNV_ST_INVALID_REQ 1
`define DNV_ST_DISABLED 2
`define DNV_ST_COMM_FAIL 3
`define DNV_ST_IN_ALARM 4
`define DNV_ST_REPORT_MASK 5

// scaling: switch percent in 0.5 % steps, level in 0.005 % steps
`define DNV_PCT_FULL 25'sh00000c8
`define DNV_LVL_FULL 33'sh000004e20
`define DNV_FREQ_DIV 16'sh000a

// timing: config times count in 0.1 s units
`define DNV_TICK_NS 100000000
`define DNV_CLK_NS 40

`endif
